// ==== include/lod_params.svh ====
// lamp overdrive timeout controller: offsets, field positions, reset values, timing counts
// assumes inclusion by bare name from design files
`ifndef LOD_PARAMS_SVH
`define LOD_PARAMS_SVH

// ****************************************
// register map
// ****************************************
`define LOD_CTRL_ADDR      8'hF7
`define LOD_CTRL_RESET     8'h00

// ****************************************
// field positions
// ****************************************
`define LOD_LEVEL_LSB      0
`define LOD_LEVEL_MSB      2
`define LOD_ENABLE_BIT     3
`define LOD_TIMEOUT_LSB    4
`define LOD_TIMEOUT_MSB    7

// ****************************************
// timing
// ****************************************
`define LOD_TIMEOUT_SHIFT  22

`endif

// ==== include/lod_pkg.sv ====
// lamp overdrive timeout controller: shared types
// assumes lod_params.svh sits on the include path
package lod_pkg;

    // control register contents, fields in bit order msb first
    typedef struct packed {
        logic [3:0] timeout;
        logic       enable;
        logic [2:0] level;
    } lod_ctrl_type;

    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lod_req_type;

    // timeout sequencer states
    typedef enum logic [1:0] {
        LOD_IDLE,
        LOD_BOOST,
        LOD_EXPIRED
    } lod_state_type;

endpackage

// ==== rtl/lod_ctrl_reg.sv ====
// lamp overdrive timeout controller: control register storage
// assumes nv shadow load strobe and register port on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "lod_params.svh"

module lod_ctrl_reg
    import lod_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         nv_load,   // shadow load from nonvolatile copy
    input  wire logic [7:0]   nv_data,   // stored copy
    input  wire logic         wr_en,     // write strobe already decoded
    input  wire logic [7:0]   wr_data,   // write data
    output lod_ctrl_type      ctrl       // registered contents
);

    // ****************************************
    // storage
    // ****************************************
    lod_ctrl_type ctrl_q;                // held value
    lod_ctrl_type ctrl_d;                // next value

    // next value: nv load wins over a write
    always_comb begin
        ctrl_d = ctrl_q;
        if (nv_load) begin
            ctrl_d = lod_ctrl_type'(nv_data);
        end else if (wr_en) begin
            ctrl_d = lod_ctrl_type'(wr_data);
        end
    end

    // register, factory value at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= lod_ctrl_type'(`LOD_CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign ctrl = ctrl_q;

endmodule
`default_nettype wire

// ==== rtl/lod_overdrive.sv ====
// lamp overdrive timeout controller: top level
// assumes clk is the lamp oscillator clock, one cycle per lamp cycle;
// the request pin is asynchronous and is synchronised here
// nv_load and the register port are already on the lamp clock
//
// Summary of operation
// - control register at F7h, loaded from nv
// - level code N boosts by (N+1)*12.5%
// - enable bit OR pin turns overdrive on
// - timeout N*2^22 lamp cycles; zero disables
// - all control bits reset to zero
`timescale 1ns/1ps
`default_nettype none
`include "lod_params.svh"

module lod_overdrive
    import lod_pkg::*;
#(
    parameter int TIMEOUT_SHIFT = `LOD_TIMEOUT_SHIFT   // lamp cycles per timeout unit, log2
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire lod_req_type  req,              // register port request
    input  wire logic         nv_load,          // shadow load strobe
    input  wire logic [7:0]   nv_data,          // stored copy
    input  wire logic         boost_request_pin, // external overdrive request
    output logic [7:0]        rdata,            // read data, registered
    output logic              overdrive_on,     // overdrive applied
    output logic [3:0]        boost_eighths,    // extra current in eighths of nominal
    output logic              timed_out         // timeout expired, running nominal
);

    // ****************************************
    // register access
    // ****************************************
    lod_ctrl_type ctrl;                         // control contents
    logic         wr_hit;                       // write to control address

    // true when a port address selects the control register; shared by reads and writes
    function automatic logic ctrl_addressed(input logic [7:0] addr);
        return (addr == `LOD_CTRL_ADDR);
    endfunction

    // address decode for writes; writes elsewhere are dropped
    assign wr_hit = req.wr && ctrl_addressed(req.addr);

    // control storage; a shadow reload beats a port write on the same edge
    lod_ctrl_reg u_ctrl (
        .clk     (clk),
        .rst     (rst),
        .nv_load (nv_load),
        .nv_data (nv_data),
        .wr_en   (wr_hit),
        .wr_data (req.wdata),
        .ctrl    (ctrl)
    );

    logic [7:0] rdata_q;                        // read data held
    logic [7:0] rdata_d;                        // read data next

    // read mux: unmapped addresses read zero
    always_comb begin
        rdata_d = rdata_q;                      // no read: keep the last byte
        if (req.rd) begin
            if (ctrl_addressed(req.addr)) begin
                // contents before any write taken on this same edge
                rdata_d = ctrl;
            end else begin
                // nothing else is mapped
                rdata_d = 8'h00;
            end
        end
    end

    // read data register, so the port sees a settled byte
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // pin synchroniser
    // ****************************************
    // the pin comes from outside the lamp clock domain; two flops keep a
    // metastable first stage away from the sequencer, at two cycles of lag
    logic pin_meta_q;                           // first stage, read only by second
    logic pin_sync_q;                           // second stage

    // two-stage capture, cleared in reset
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= boost_request_pin;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ****************************************
    // timeout sequencer
    // ****************************************
    // one wide counter of lamp cycles; four extra bits hold the largest timeout field
    localparam int CW = TIMEOUT_SHIFT + 4;      // counter width

    logic          request;                     // combined request
    logic [CW-1:0] limit;                       // cycles to expiry
    logic          timeout_armed;               // nonzero timeout field
    logic [CW-1:0] cnt_next;                    // count one cycle on
    logic          expire_now;                  // this edge reaches the limit
    lod_state_type state_q;                     // sequencer state
    lod_state_type state_d;                     // next state
    logic [CW-1:0] cnt_q;                       // lamp cycles in overdrive
    logic [CW-1:0] cnt_d;                       // next count

    // either source alone is enough to ask for overdrive
    assign request = ctrl.enable | pin_sync_q;
    // field value times the unit, as a shift of the four-bit field
    assign limit   = CW'({ctrl.timeout, {TIMEOUT_SHIFT{1'b0}}});
    // a zero field leaves overdrive on for as long as it is asked for
    assign timeout_armed = (ctrl.timeout != 4'h0);
    assign cnt_next      = cnt_q + CW'(1);
    // a new, smaller field takes effect at once against the running count
    assign expire_now    = timeout_armed && (cnt_next >= limit);

    // next state and count
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            // waiting for a request; counter starts fresh
            LOD_IDLE: begin
                cnt_d = '0;
                if (request) begin
                    // overdrive starts on the next edge
                    state_d = LOD_BOOST;
                end
            end
            // overdrive applied, counting lamp cycles
            LOD_BOOST: begin
                if (!request) begin
                    // request withdrawn: nominal, timer re-arms
                    state_d = LOD_IDLE;
                end else if (expire_now) begin
                    // limit reached: back to nominal current
                    state_d = LOD_EXPIRED;
                end else if (timeout_armed) begin
                    // still inside the timeout window
                    cnt_d = cnt_next;
                end
            end
            // expired: nominal until request drops
            LOD_EXPIRED: begin
                if (!request) begin
                    // only a dropped request re-arms the timer
                    state_d = LOD_IDLE;
                end
            end
            // unused encoding: recover to idle
            default: begin
                state_d = LOD_IDLE;
            end
        endcase
    end

    // state and count registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= LOD_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic       on_q;                           // overdrive applied
    logic       on_d;
    logic [3:0] eighths_q;                      // boost amount
    logic [3:0] eighths_d;
    logic       to_q;                           // expired flag
    logic       to_d;

    // registered outputs follow the next state, so they move on the same edge as the state
    always_comb begin
        on_d = (state_d == LOD_BOOST);
        to_d = (state_d == LOD_EXPIRED);
        if (on_d) begin
            // code N adds N+1 eighths of nominal on top of nominal
            eighths_d = {1'b0, ctrl.level} + 4'h1;
        end else begin
            // nominal current: no boost at all
            eighths_d = 4'h0;
        end
    end

    // output registers, cleared in reset
    always_ff @(posedge clk) begin
        if (rst) begin
            on_q      <= 1'b0;
            eighths_q <= 4'h0;
            to_q      <= 1'b0;
        end else begin
            on_q      <= on_d;
            eighths_q <= eighths_d;
            to_q      <= to_d;
        end
    end

    // every output leaves straight from its flip-flop
    assign rdata         = rdata_q;
    assign overdrive_on  = on_q;
    assign boost_eighths = eighths_q;
    assign timed_out     = to_q;

endmodule
`default_nettype wire

// ==== testbench/lod_overdrive_monitor.sv ====
// lamp overdrive checker: output relations of the top level
// assumes a bind to lod_overdrive, one clock
`timescale 1ns/1ps
`default_nettype none
`include "lod_params.svh"
module lod_overdrive_monitor
    import lod_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire lod_req_type req,
    input wire logic        nv_load,
    input wire logic        boost_request_pin,
    input wire logic [7:0]  rdata,
    input wire logic        overdrive_on,
    input wire logic [3:0]  boost_eighths,
    input wire logic        timed_out
);
    // ****************************************
    // checks, all but a_reset_clears_outputs masked in reset
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_off_no_boost: assert property (!overdrive_on |-> boost_eighths == 4'h0)
        else $error("boost level while overdrive off");
    a_boost_in_range: assert property (overdrive_on |-> boost_eighths inside {[4'h1:4'h8]})
        else $error("boost level out of range");
    a_expired_is_off: assert property (timed_out |-> !overdrive_on)
        else $error("overdrive on after expiry");
    a_expiry_ends_boost: assert property ($rose(timed_out) |-> $past(overdrive_on))
        else $error("expiry without active overdrive");
    a_unmapped_zero: assert property (req.rd && req.addr != `LOD_CTRL_ADDR |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!req.rd |=> $stable(rdata))
        else $error("read data moved without read");
    a_enable_starts_boost: assert property (req.wr && req.addr == `LOD_CTRL_ADDR && !nv_load
        && req.wdata[`LOD_ENABLE_BIT] |-> ##2 (overdrive_on || timed_out))
        else $error("enable bit written but no overdrive");
    a_pin_starts_boost: assert property (boost_request_pin [*3] |-> ##1 (overdrive_on || timed_out))
        else $error("request pin held but no overdrive");
    a_reset_clears_outputs: assert property (disable iff (1'b0) rst |=> !overdrive_on && !timed_out
        && boost_eighths == 4'h0 && rdata == 8'h00)
        else $error("outputs not cleared by reset");
endmodule
bind lod_overdrive lod_overdrive_monitor mon_u (.clk(clk), .rst(rst), .req(req), .nv_load(nv_load),
    .boost_request_pin(boost_request_pin), .rdata(rdata), .overdrive_on(overdrive_on),
    .boost_eighths(boost_eighths), .timed_out(timed_out));
`default_nettype wire

// ==== testbench/test_lamp_overdrive_timeout_ctrl.sv ====
// lamp overdrive bench: register, level, pin and timeout checks
// assumes lod_overdrive with a short timeout unit
`timescale 1ns/1ps
`default_nettype none
module test_lamp_overdrive_timeout_ctrl
    import lod_pkg::*;
;
    localparam int SHIFT = 3;       // short timeout unit
    logic        clk = 1'b0;        // lamp clock
    logic        rst = 1'b1;        // sync reset
    lod_req_type req = '0;          // register port
    logic        nv_load = 1'b0;    // shadow load
    logic [7:0]  nv_data = 8'h00;   // stored copy
    logic        pin = 1'b0;        // external request
    logic [7:0]  rdata;
    logic        on;
    logic        tmo;
    logic [3:0]  eighths;
    int          errors = 0;
    int          check_count = 0;
    int          n;
    int          c;
    logic [7:0]  v;
    always #5 clk = ~clk;
    lod_overdrive #(.TIMEOUT_SHIFT(SHIFT)) dut_u (.clk(clk), .rst(rst), .req(req), .nv_load(nv_load),
        .nv_data(nv_data), .boost_request_pin(pin), .rdata(rdata), .overdrive_on(on),
        .boost_eighths(eighths), .timed_out(tmo));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] exp_cycles(input int t);
        return 8'(t << SHIFT);
    endfunction
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one register cycle, read when wr low
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        #1;
    endtask
    // bounded wait for an overdrive level
    task automatic wait_on(input logic lvl);
        for (int i = 0; i < 40 && on !== lvl; i++) @(posedge clk) #1;
        if (on !== lvl) begin
            errors++;
            final_report();
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        v = 8'($urandom(32'h2f6b));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        access(0, 8'hF7, 8'h00);
        check(rdata, 8'h00);
        for (n = 0; n < 8; n++) begin
            v = 8'($urandom);
            access(1, 8'hF7, v);
            access(1, {v[6:0], 1'b0}, ~v);
            access(0, 8'hF7, 8'h00);
            check(rdata, v);
            access(0, {v[6:0], 1'b0}, 8'h00);
            check(rdata, 8'h00);
        end
        @(posedge clk);
        nv_data <= 8'($urandom);
        nv_load <= 1'b1;
        @(posedge clk);
        nv_load <= 1'b0;
        access(0, 8'hF7, 8'h00);
        check(rdata, nv_data);
        // reload and port write on one edge: the stored copy wins
        @(posedge clk);
        nv_load <= 1'b1;
        req     <= '{wr: 1'b1, rd: 1'b0, addr: 8'hF7, wdata: ~nv_data};
        @(posedge clk);
        nv_load <= 1'b0;
        req     <= '0;
        access(0, 8'hF7, 8'h00);
        check(rdata, nv_data);
        for (n = 0; n < 8; n++) begin
            access(1, 8'hF7, 8'h00);
            wait_on(1'b0);
            access(1, 8'hF7, {5'h01, n[2:0]});
            wait_on(1'b1);
            check({4'h0, eighths}, 8'(n + 1));
        end
        repeat (200) @(posedge clk);
        #1;
        check({7'h0, on}, 8'h01);
        access(1, 8'hF7, 8'h00);
        wait_on(1'b0);
        @(posedge clk);
        pin <= 1'b1;
        wait_on(1'b1);
        check({4'h0, eighths}, 8'h01);
        @(posedge clk);
        pin <= 1'b0;
        wait_on(1'b0);
        for (n = 0; n < 3; n++) begin
            v = (n == 0) ? 8'h01 : (n == 1) ? 8'h0F : 8'(2 + $urandom % 13);
            access(1, 8'hF7, {v[3:0], 4'h8});
            wait_on(1'b1);
            for (c = 0; on === 1'b1 && c < 200; c++) @(posedge clk) #1;
            check(8'(c), exp_cycles(v));
            repeat (4) @(posedge clk);
            #1;
            check({6'h0, tmo, on}, 8'h02);
            access(1, 8'hF7, 8'h00);
            @(posedge clk);
            #1;
            check({7'h0, tmo}, 8'h00);
        end
        final_report();
    end
endmodule
`default_nettype wire
